// File: logic/light_sensor_regs.vh
// Register map, field positions, reset values and timing counts of the light sensor target.
// Assumes a 50 MHz system clock; included by the interface module only.
`ifndef LIGHT_SENSOR_REGS_VH
`define LIGHT_SENSOR_REGS_VH

`define TARGET_ADDRESS 7'h10
`define ADDR_LIGHT_CONFIG 8'h00
`define ADDR_HIGH_THRESHOLD 8'h01
`define ADDR_LOW_THRESHOLD 8'h02
`define ADDR_POWER_SAVING 8'h03
`define ADDR_LIGHT_RESULT 8'h04
`define ADDR_BROADBAND_RESULT 8'h05
`define ADDR_EVENT_STATUS 8'h06

`define LIGHT_CONFIG_RESET 16'h0001
`define POWER_SAVING_RESET 16'h0000
`define THRESHOLD_RESET 16'h0000

`define CFG_SHUTDOWN_BIT 0
`define CFG_IRQ_ENABLE_BIT 1
`define CFG_PERSIST_LSB 4
`define CFG_PERSIST_MSB 5
`define CFG_IT_LSB 6
`define CFG_IT_MSB 9
`define CFG_GAIN_LSB 11
`define CFG_GAIN_MSB 12
`define PSM_ENABLE_BIT 0
`define PSM_MODE_LSB 1
`define PSM_MODE_MSB 2
`define EVENT_HIGH_BIT 14
`define EVENT_LOW_BIT 15

`define CLOCK_HZ 50000000
`define TIMEOUT_MIN_MS 25
`define TIMEOUT_CYCLES ((`TIMEOUT_MIN_MS * `CLOCK_HZ) / 1000)

`endif

// File: logic/light_sensor_target.v
// I2C target and register file of an ambient light sensor, with threshold event logic.
// Assumes SCL and SDA arrive unsynchronised from open-drain pins and that converter
// samples arrive as a one-cycle strobe on i_clock.
`include "light_sensor_regs.vh"

module light_sensor_target #(
	parameter TIMEOUT_CYCLES = `TIMEOUT_CYCLES
)(
	// Clock and reset.
	input wire i_clock,
	input wire i_reset,
	// I2C pins; SDA is open drain.
	input wire i_scl,
	input wire i_sda,
	output reg o_sda_out,
	output reg o_sda_oe_n,
	// Converter samples.
	input wire i_sample_valid,
	input wire [15:0] i_light_sample,
	input wire [15:0] i_broadband_sample,
	// Front end controls and status.
	output reg [1:0] o_gain_select,
	output reg [3:0] o_integration_time_select,
	output reg o_shutdown,
	output reg [1:0] o_power_saving_mode_select,
	output reg o_power_saving_enable,
	output reg o_bus_timeout
);

localparam ST_IDLE = 4'h0;
localparam ST_ADDR = 4'h1;
localparam ST_ADDR_ACK = 4'h2;
localparam ST_CMD = 4'h3;
localparam ST_CMD_ACK = 4'h4;
localparam ST_WDATA = 4'h5;
localparam ST_WDATA_ACK = 4'h6;
localparam ST_RDATA = 4'h7;
localparam ST_RDATA_ACK = 4'h8;

////////////////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers: a level is accepted once the second and third stages agree.

reg [2:0] scl_sync_reg;
reg [2:0] sda_sync_reg;
reg scl_reg;
reg sda_reg;

always @(posedge i_clock or posedge i_reset)
begin
	if (i_reset)
	begin
		scl_sync_reg <= 3'h7;
		sda_sync_reg <= 3'h7;
		scl_reg <= 1'b1;
		sda_reg <= 1'b1;
	end
	else
	begin
		scl_sync_reg <= {scl_sync_reg[1:0], i_scl};
		sda_sync_reg <= {sda_sync_reg[1:0], i_sda};
		if (scl_sync_reg[1] == scl_sync_reg[2])
			scl_reg <= scl_sync_reg[2];
		if (sda_sync_reg[1] == sda_sync_reg[2])
			sda_reg <= sda_sync_reg[2];
	end
end

// Filtered levels change only between sampled edges, so one edge is one event.
wire scl_rise = (scl_sync_reg[1] == scl_sync_reg[2]) && scl_sync_reg[2] && !scl_reg;
wire scl_fall = (scl_sync_reg[1] == scl_sync_reg[2]) && !scl_sync_reg[2] && scl_reg;
wire sda_new = (sda_sync_reg[1] == sda_sync_reg[2]) ? sda_sync_reg[2] : sda_reg;
wire start_seen = scl_reg && sda_reg && !sda_new;
wire stop_seen = scl_reg && !sda_reg && sda_new;

////////////////////////////////////////////////////////////////////////////////////////////
// Registers and read multiplexer.

reg [15:0] config_reg;
reg [15:0] high_threshold_reg;
reg [15:0] low_threshold_reg;
reg [15:0] power_saving_reg;
reg [15:0] light_result_reg;
reg [15:0] broadband_result_reg;
reg [15:0] event_status_reg;
reg [3:0] persist_count_reg;

reg [3:0] state_reg;
reg [3:0] bit_count_reg;
reg [7:0] shift_reg;
reg [7:0] tx_reg;
reg [7:0] pointer_reg;
reg [7:0] low_byte_reg;
reg byte_index_reg;
reg host_nack_reg;
reg [31:0] low_count_reg;
reg write_strobe_reg;
reg clear_status_reg;

// Unmapped codes read as zero.
reg [15:0] read_word;
always @*
begin
	case (pointer_reg)
		`ADDR_LIGHT_RESULT: read_word = light_result_reg;
		`ADDR_BROADBAND_RESULT: read_word = broadband_result_reg;
		`ADDR_EVENT_STATUS: read_word = event_status_reg;
		default: read_word = 16'h0000;
	endcase
end

////////////////////////////////////////////////////////////////////////////////////////////
// I2C target state machine. SDA changes only after SCL falls, so setup time is a half period.

always @(posedge i_clock or posedge i_reset)
begin
	if (i_reset)
	begin
		state_reg <= ST_IDLE;
		bit_count_reg <= 4'h0;
		shift_reg <= 8'h00;
		tx_reg <= 8'h00;
		pointer_reg <= 8'h00;
		low_byte_reg <= 8'h00;
		byte_index_reg <= 1'b0;
		host_nack_reg <= 1'b0;
		o_sda_out <= 1'b0;
		o_sda_oe_n <= 1'b1;
		low_count_reg <= 32'h0;
		o_bus_timeout <= 1'b0;
		write_strobe_reg <= 1'b0;
		clear_status_reg <= 1'b0;
	end
	else
	begin
		write_strobe_reg <= 1'b0;
		clear_status_reg <= 1'b0;
		o_bus_timeout <= 1'b0;
		if (scl_reg && sda_reg)
			low_count_reg <= 32'h0;
		else if (low_count_reg != TIMEOUT_CYCLES)
			low_count_reg <= low_count_reg + 32'h1;
		if (low_count_reg == TIMEOUT_CYCLES - 1)
		begin
			// A stuck bus frees itself: drop the transfer and let go of SDA.
			o_bus_timeout <= 1'b1;
			state_reg <= ST_IDLE;
			o_sda_oe_n <= 1'b1;
		end
		else if (start_seen)
		begin
			// Repeated start keeps the command code for the read that follows.
			state_reg <= ST_ADDR;
			bit_count_reg <= 4'h0;
			o_sda_oe_n <= 1'b1;
		end
		else if (stop_seen)
		begin
			state_reg <= ST_IDLE;
			o_sda_oe_n <= 1'b1;
		end
		else if (scl_rise)
		begin
			shift_reg <= {shift_reg[6:0], sda_new};
			bit_count_reg <= bit_count_reg + 4'h1;
			if (state_reg == ST_RDATA)
				tx_reg <= {tx_reg[6:0], 1'b0};
			if (state_reg == ST_RDATA_ACK)
				host_nack_reg <= sda_new;
		end
		else if (scl_fall)
		begin
			case (state_reg)
				ST_ADDR:
					if (bit_count_reg == 4'h8)
					begin
						if (shift_reg[7:1] == `TARGET_ADDRESS)
						begin
							o_sda_oe_n <= 1'b0;
							state_reg <= ST_ADDR_ACK;
						end
						else
							state_reg <= ST_IDLE;
					end
				ST_ADDR_ACK:
				begin
					bit_count_reg <= 4'h0;
					byte_index_reg <= 1'b0;
					// The acknowledge bit has been shifted in, so the direction bit sits one up.
					if (shift_reg[1])
					begin
						tx_reg <= read_word[7:0];
						o_sda_oe_n <= read_word[7];
						state_reg <= ST_RDATA;
					end
					else
					begin
						o_sda_oe_n <= 1'b1;
						state_reg <= ST_CMD;
					end
				end
				ST_CMD:
					if (bit_count_reg == 4'h8)
					begin
						pointer_reg <= shift_reg;
						o_sda_oe_n <= 1'b0;
						state_reg <= ST_CMD_ACK;
					end
				ST_CMD_ACK, ST_WDATA_ACK:
				begin
					o_sda_oe_n <= 1'b1;
					bit_count_reg <= 4'h0;
					byte_index_reg <= (state_reg == ST_WDATA_ACK);
					state_reg <= ST_WDATA;
				end
				ST_WDATA:
					if (bit_count_reg == 4'h8)
					begin
						o_sda_oe_n <= 1'b0;
						state_reg <= ST_WDATA_ACK;
						if (!byte_index_reg)
							low_byte_reg <= shift_reg;
						else
							write_strobe_reg <= 1'b1;
					end
				ST_RDATA:
					if (bit_count_reg == 4'h8)
					begin
						o_sda_oe_n <= 1'b1;
						state_reg <= ST_RDATA_ACK;
					end
					else
						o_sda_oe_n <= tx_reg[7];
				ST_RDATA_ACK:
				begin
					bit_count_reg <= 4'h0;
					if (host_nack_reg)
					begin
						// The host ends the read; SDA stays released until the stop.
						o_sda_oe_n <= 1'b1;
						state_reg <= ST_IDLE;
						clear_status_reg <= (pointer_reg == `ADDR_EVENT_STATUS);
					end
					else
					begin
						byte_index_reg <= ~byte_index_reg;
						tx_reg <= byte_index_reg ? read_word[7:0] : read_word[15:8];
						o_sda_oe_n <= byte_index_reg ? read_word[7] : read_word[15];
						state_reg <= ST_RDATA;
					end
				end
				default:
					o_sda_oe_n <= 1'b1;
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////////////////////////
// Register writes, measurement capture and threshold events.

wire [15:0] write_word = {shift_reg, low_byte_reg};
wire shut_down = config_reg[`CFG_SHUTDOWN_BIT];
wire take_sample = i_sample_valid && !shut_down;
wire above_high = i_light_sample > high_threshold_reg;
wire below_low = i_light_sample < low_threshold_reg;
wire [3:0] persist_target = 4'h1 << config_reg[`CFG_PERSIST_MSB:`CFG_PERSIST_LSB];
wire [3:0] persist_next = (persist_count_reg == 4'h8) ? 4'h8 : persist_count_reg + 4'h1;
wire event_fire = take_sample && (above_high || below_low)
	&& (persist_next >= persist_target) && config_reg[`CFG_IRQ_ENABLE_BIT];
reg [15:0] event_set;

always @*
begin
	event_set = 16'h0000;
	event_set[`EVENT_HIGH_BIT] = event_fire && above_high;
	event_set[`EVENT_LOW_BIT] = event_fire && below_low;
end

always @(posedge i_clock or posedge i_reset)
begin
	if (i_reset)
	begin
		config_reg <= `LIGHT_CONFIG_RESET;
		high_threshold_reg <= `THRESHOLD_RESET;
		low_threshold_reg <= `THRESHOLD_RESET;
		power_saving_reg <= `POWER_SAVING_RESET;
		light_result_reg <= 16'h0000;
		broadband_result_reg <= 16'h0000;
		event_status_reg <= 16'h0000;
		persist_count_reg <= 4'h0;
	end
	else
	begin
		if (write_strobe_reg)
		begin
			// Reserved bits are stored as written; the host keeps them zero.
			case (pointer_reg)
				`ADDR_LIGHT_CONFIG: config_reg <= write_word;
				`ADDR_HIGH_THRESHOLD: high_threshold_reg <= write_word;
				`ADDR_LOW_THRESHOLD: low_threshold_reg <= write_word;
				`ADDR_POWER_SAVING: power_saving_reg <= write_word;
				default: ;
			endcase
		end
		if (take_sample)
		begin
			light_result_reg <= i_light_sample;
			broadband_result_reg <= i_broadband_sample;
			persist_count_reg <= (above_high || below_low) ? persist_next : 4'h0;
		end
		// A new event in the clearing cycle survives the clear.
		event_status_reg <= (clear_status_reg ? 16'h0000 : event_status_reg) | event_set;
	end
end

////////////////////////////////////////////////////////////////////////////////////////////
// Front end controls, each held in its own flip-flop.

always @(posedge i_clock or posedge i_reset)
begin
	if (i_reset)
	begin
		o_gain_select <= 2'h0;
		o_integration_time_select <= 4'h0;
		o_shutdown <= 1'b1;
		o_power_saving_mode_select <= 2'h0;
		o_power_saving_enable <= 1'b0;
	end
	else
	begin
		o_gain_select <= config_reg[`CFG_GAIN_MSB:`CFG_GAIN_LSB];
		o_integration_time_select <= config_reg[`CFG_IT_MSB:`CFG_IT_LSB];
		o_shutdown <= shut_down;
		o_power_saving_mode_select <= power_saving_reg[`PSM_MODE_MSB:`PSM_MODE_LSB];
		o_power_saving_enable <= power_saving_reg[`PSM_ENABLE_BIT];
	end
end

endmodule

// File: testbench/light_sensor_i2c_host.sv
// Behavioural I2C host that drives the sensor's bus pins.
// Assumes a pull-up on SDA: o_sda high means released.
module light_sensor_i2c_host (
	// Bus pins.
	output logic o_scl,
	output logic o_sda,
	input wire logic i_sda_line
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	////////////////////////////////////////////////////////////////////////////
	// Low phase is stretched so the answer settles before the rising edge.
	task automatic bit_io(input logic tx, output logic rx);
		#60 o_sda = tx;
		#140 o_scl = 1'b1;
		#100 rx = i_sda_line;
		#20 o_scl = 1'b0;
	endtask
	task automatic start_cond;
		#120 o_sda = 1'b1;
		#100 o_scl = 1'b1;
		#160 o_sda = 1'b0;
		#160 o_scl = 1'b0;
	endtask
	task automatic stop_cond;
		#60 o_sda = 1'b0;
		#140 o_scl = 1'b1;
		#160 o_sda = 1'b1;
		#160;
	endtask
	task automatic byte_io(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
		output logic ack_out);
		for (int i = 7; i >= 0; i--)
			bit_io(tx[i], rx[i]);
		bit_io(ack_in, ack_out);
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic write_reg(input logic [6:0] addr, input logic [7:0] cmd,
		input logic [15:0] data, output logic [3:0] nak);
		logic [7:0] rx;
		start_cond();
		byte_io({addr, 1'b0}, 1'b1, rx, nak[3]);
		byte_io(cmd, 1'b1, rx, nak[2]);
		byte_io(data[7:0], 1'b1, rx, nak[1]);
		byte_io(data[15:8], 1'b1, rx, nak[0]);
		stop_cond();
	endtask
	task automatic read_reg(input logic [7:0] cmd, output logic [15:0] data);
		logic [7:0] rx;
		logic ack;
		start_cond();
		byte_io(8'h20, 1'b1, rx, ack);
		byte_io(cmd, 1'b1, rx, ack);
		start_cond();
		byte_io(8'h21, 1'b1, rx, ack);
		byte_io(8'hff, 1'b0, data[7:0], ack);
		byte_io(8'hff, 1'b1, data[15:8], ack);
		stop_cond();
	endtask
	task automatic hold_low(input int cycles);
		#40 o_scl = 1'b0;
		#(cycles * 20) o_scl = 1'b1;
	endtask
endmodule

// File: testbench/light_sensor_i2c_register_interface_tb_top.sv
// Register-level tests of the light sensor target through its I2C pins.
// Assumes the host model and the bound checker are compiled alongside.
module light_sensor_i2c_register_interface_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TMO = 2000;
	logic i_clock = 1'b0;
	logic i_reset = 1'b1;
	logic scl, sda_host, valid;
	logic [15:0] light, broad, v;
	logic [3:0] nak;
	wire sda_out, sda_oe_n, sd, power_saving_enable, tmo;
	wire [1:0] gain, power_saving_mode_select;
	wire [3:0] itime;
	wire sda_line = sda_host & (sda_oe_n ? 1'b1 : sda_out);
	logic [3:0] its [4] = '{4'hc, 4'h8, 4'h2, 4'h3};
	int miscompares = 0;
	int checks_done = 0;
	int tmo_seen = 0;
	light_sensor_target #(.TIMEOUT_CYCLES(TMO)) u_dut (.i_clock(i_clock), .i_reset(i_reset),
		.i_scl(scl), .i_sda(sda_line), .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n),
		.i_sample_valid(valid), .i_light_sample(light), .i_broadband_sample(broad),
		.o_gain_select(gain), .o_integration_time_select(itime), .o_shutdown(sd),
		.o_power_saving_mode_select(power_saving_mode_select), .o_power_saving_enable(power_saving_enable), .o_bus_timeout(tmo));
	light_sensor_i2c_host u_host (.o_scl(scl), .o_sda(sda_host), .i_sda_line(sda_line));
	always #10 i_clock = ~i_clock;
	always @(posedge i_clock)
		if (tmo === 1'b1)
			tmo_seen++;
	////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		if (miscompares == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
		u_host.write_reg(7'h10, cmd, d, nak);
		check({12'h0, nak}, 16'h0);
	endtask
	task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
		u_host.read_reg(cmd, v);
		check(v, exp);
	endtask
	task automatic sample(input logic [15:0] l, input logic [15:0] b);
		@(posedge i_clock);
		#1 valid = 1'b1;
		light = l;
		broad = b;
		@(posedge i_clock);
		#1 valid = 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#1500000;
		miscompares++;
		test_done();
	end
	initial
	begin
		valid = 1'b0;
		light = 16'h0;
		broad = 16'h0;
		repeat (8) @(posedge i_clock);
		#1 i_reset = 1'b0;
		repeat (4) @(posedge i_clock);
		check({15'h0, sd}, 16'h1);
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h00, {3'h0, i[1:0], 1'b0, its[i], 6'h0});
			check({14'h0, gain}, {14'h0, i[1:0]});
			check({12'h0, itime}, {12'h0, its[i]});
			check({15'h0, sd}, 16'h0);
			wr(8'h03, {13'h0, i[1:0], i[0]});
			check({13'h0, power_saving_mode_select, power_saving_enable}, {13'h0, i[1:0], i[0]});
		end
		sample(16'h1234, 16'h5678);
		rd(8'h04, 16'h1234);
		rd(8'h05, 16'h5678);
		wr(8'h04, 16'hffff);
		rd(8'h04, 16'h1234);
		rd(8'h07, 16'h0000);
		u_host.write_reg(7'h11, 8'h00, 16'h0001, nak);
		check({12'h0, nak}, 16'hf);
		check({15'h0, sd}, 16'h0);
		wr(8'h00, 16'h0001);
		sample(16'h9999, 16'h9999);
		rd(8'h04, 16'h1234);
		wr(8'h00, 16'h0000);
		sample(16'h4321, 16'h0000);
		rd(8'h04, 16'h4321);
		// Values are chosen so that swapped threshold bytes change the outcome.
		wr(8'h01, 16'h0130);
		wr(8'h02, 16'h0100);
		wr(8'h00, 16'h0012);
		// An in-window sample restarts the persistence run left by earlier samples.
		sample(16'h0120, 16'h0000);
		sample(16'h0200, 16'h0000);
		rd(8'h06, 16'h0000);
		sample(16'h0200, 16'h0000);
		rd(8'h06, 16'h4000);
		rd(8'h06, 16'h0000);
		wr(8'h00, 16'h0000);
		sample(16'h0050, 16'h0000);
		rd(8'h06, 16'h0000);
		wr(8'h00, 16'h0002);
		sample(16'h0050, 16'h0000);
		rd(8'h06, 16'h8000);
		u_host.hold_low(TMO + 100);
		check(tmo_seen[15:0], 16'h1);
		test_done();
	end
endmodule

// File: testbench/light_sensor_target_asserts.sv
// Reset, open-drain and timing checks on the sensor target's pins.
// Assumes it is bound into the target and sees raw, unsynchronised bus pins.
module light_sensor_target_asserts #(
	parameter TIMEOUT_CYCLES = 1250000
)(
	input wire i_clock,
	input wire i_reset,
	input wire i_scl,
	input wire i_sda,
	input wire o_sda_out,
	input wire o_sda_oe_n,
	input wire [1:0] o_gain_select,
	input wire [3:0] o_integration_time_select,
	input wire o_shutdown,
	input wire [1:0] o_power_saving_mode_select,
	input wire o_power_saving_enable,
	input wire o_bus_timeout
);
	localparam int LIM = TIMEOUT_CYCLES + 16;
	logic [31:0] low_cnt;
	logic [31:0] scl_cnt;
	logic seen;
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_reset);
	// Raw pins lead the design's filtered view, so these runs never undercount.
	always @(posedge i_clock or posedge i_reset)
	begin
		if (i_reset)
		begin
			low_cnt <= 32'h0;
			scl_cnt <= 32'h0;
			seen <= 1'b0;
		end
		else
		begin
			low_cnt <= (i_scl && i_sda) ? 32'h0 : ((low_cnt == LIM) ? low_cnt : low_cnt + 1);
			scl_cnt <= i_scl ? 32'h0 : ((scl_cnt == LIM) ? scl_cnt : scl_cnt + 1);
			seen <= (i_scl && i_sda) ? 1'b0 : (seen || o_bus_timeout);
		end
	end
	sequence scl_stuck;
		scl_cnt == TIMEOUT_CYCLES + 10;
	endsequence
	////////////////////////////////////////////////////////////////////////////
	reset_config_a: assert property ($fell(i_reset) |-> o_shutdown && o_gain_select == 2'h0
		&& o_integration_time_select == 4'h0 && !o_power_saving_enable) else $error("bad reset");
	reset_bus_a: assert property ($fell(i_reset) |-> o_sda_oe_n && !o_bus_timeout)
		else $error("bus busy after reset");
	open_drain_a: assert property (!o_sda_out) else $error("sda driven high");
	drive_scl_low_a: assert property ($fell(o_sda_oe_n) |-> !$past(i_scl, 3))
		else $error("sda taken while scl high");
	ctrl_change_a: assert property ($changed({o_gain_select, o_integration_time_select,
		o_shutdown, o_power_saving_mode_select, o_power_saving_enable}) |-> !$past(i_scl, 2))
		else $error("control changed outside a write");
	timeout_late_a: assert property (o_bus_timeout |-> low_cnt >= TIMEOUT_CYCLES)
		else $error("timeout too early");
	timeout_due_a: assert property (scl_stuck |-> seen) else $error("timeout missing");
	timeout_pulse_a: assert property (o_bus_timeout |=> !o_bus_timeout)
		else $error("timeout longer than a cycle");
endmodule
bind light_sensor_target light_sensor_target_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_asserts (
	.i_clock(i_clock), .i_reset(i_reset), .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out),
	.o_sda_oe_n(o_sda_oe_n), .o_gain_select(o_gain_select),
	.o_integration_time_select(o_integration_time_select), .o_shutdown(o_shutdown),
	.o_power_saving_mode_select(o_power_saving_mode_select),
	.o_power_saving_enable(o_power_saving_enable), .o_bus_timeout(o_bus_timeout));
